// ==== bench/ccr_config_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module ccr_config_regs_tb;
  import ccr_pkg::*;
  // short second keeps the 40s watchdog within a few thousand cycles
  localparam int TICK = 200;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic        reg_reset = 1'b0;
  logic        kick      = 1'b0;
  logic [6:0]  fast_cur  = 7'h20;
  logic        host_scl;
  logic        host_oe_n;
  logic        dut_oe_n;
  logic        kick_clr;
  logic        expired;
  ccr_cfg_t    cfg;
  logic [23:0] q;
  logic        nak;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n_exp = 0;
  int          n_clr = 0;
  logic [23:0] rows [4] = '{24'hff_0000, 24'hc4_5aff, 24'hc0_a455, 24'h01_ffaa};
  logic [6:0]  ics [4]  = '{7'h00, 7'h4f, 7'h7f, 7'h10};
  // open drain with pull-up: low when either side pulls
  wire logic   sda_w = host_oe_n & dut_oe_n;

  ccr_config_regs #(.TICK_CYCLES_P(TICK), .DEV_ADDR(7'h40)) uut (
    .sys_clk_in              (clk),
    .reset_n_in              (reset_n),
    .scl_in                  (host_scl),
    .sda_in                  (sda_w),
    .sda_out                 (),
    .sda_oe_n_out            (dut_oe_n),
    .reg_reset_in            (reg_reset),
    .watchdog_kick_in        (kick),
    .fast_charge_current_in  (fast_cur),
    .watchdog_kick_clear_out (kick_clr),
    .watchdog_expired_out    (expired),
    .cfg_out                 (cfg)
  );

  ccr_host_model #(.DEV_ADDR(7'h40)) host (
    .sys_clk_in   (clk),
    .sda_in       (sda_w),
    .scl_out      (host_scl),
    .sda_oe_n_out (host_oe_n)
  );

  always #10 clk = ~clk;

  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (expired === 1'b1) n_exp++;
    if (kick_clr === 1'b1) n_clr++;
    if (cyc == 60000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] st(input logic [7:0] cv);
    return (cv[7:2] > 6'h30) ? {6'h30, cv[1:0]} : cv;
  endfunction

  function automatic ccr_cfg_t exp_cfg(input logic [7:0] cv, tt, ir, input logic [6:0] ic);
    ccr_cfg_t e;
    int       lim;
    int       drop;
    int       ma;
    lim = 3840 + 16 * cv[7:2];
    ma = 64 * ic;
    drop = ma * 20 * ir[7:5] / 1000;
    if (drop > 32 * ir[4:2]) drop = 32 * ir[4:2];
    e.charge_voltage_limit_mv = 16'(lim);
    e.charge_voltage_target_mv = 16'(lim + drop);
    e.precharge_exit_mv = 16'(cv[1] ? 3000 : 2800);
    e.recharge_mv = 16'(lim - (cv[0] ? 200 : 100));
    e.term_en = tt[7];
    e.indicator_pin_off = tt[6];
    e.watchdog_period_s = 8'(tt[5:4] == 0 ? 0 : 20 << tt[5:4]);
    e.safety_timer_en = tt[3];
    e.fast_charge_hours = 5'(tt[2:1] == 0 ? 5 : tt[2:1] == 1 ? 8 : tt[2:1] == 2 ? 12 : 20);
    e.charge_enable = (ic != 7'h00);
    e.cool_current_ma = 16'(ma * (tt[0] ? 20 : 50) / 100);
    e.ir_comp_resistance_mohm = 8'(20 * ir[7:5]);
    e.ir_comp_voltage_max_mv = 8'(32 * ir[4:2]);
    e.thermal_reg_threshold_c = 8'(60 + 20 * ir[1:0]);
    return e;
  endfunction

  // burst read of all three registers, then the decoded settings
  task automatic check_all(input logic [7:0] cv, tt, ir);
    host.reg_read(8'h06, 3, q, nak);
    check(128'(q), 128'({cv, tt, ir}));
    check(128'(nak), 128'(0));
    w(2);
    check(128'(cfg), 128'(exp_cfg(cv, tt, ir, fast_cur)));
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    w(4);
    check_all(8'h5e, 8'h9d, 8'h03);
    for (int r = 0; r < 4; r++) begin
      fast_cur = ics[r];
      host.reg_write(8'h06, rows[r], 3, nak);
      check_all(st(rows[r][23:16]), rows[r][15:8], rows[r][7:0]);
    end
    // unmapped 0x05 reads as zero ahead of the live registers
    host.reg_read(8'h05, 3, q, nak);
    check(128'(q), 128'(24'h00_01ff));
    reg_reset = 1'b1;
    w(1);
    reg_reset = 1'b0;
    w(3);
    check(128'(cfg), 128'(exp_cfg(8'h5e, 8'h9d, 8'h03, fast_cur)));
    host.reg_write(8'h06, 24'h10_0000, 1, nak);
    // first kick clears the count left by earlier traffic, which a register
    // reset does not touch; the last lands after the first period would have run out
    for (int k = 0; k <= 2; k++) begin
      w(3000 * k);
      kick = 1'b1;
      w(1);
      kick = 1'b0;
      w(2);
      check(128'(n_clr), 128'(k + 1));
    end
    check(128'(n_exp), 128'(0));
    w(40 * TICK - 25);
    check(128'(n_exp), 128'(0));
    w(30);
    check(128'(n_exp), 128'(1));
    w(2);
    check_all(8'h5e, 8'h9d, 8'h03);
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== bench/ccr_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ccr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h40  // arbitrary value
) (
  input  wire logic sys_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_n_out
);
  // clock parks high between frames, data released to the pull-up
  initial begin
    scl_out      = 1'b1;
    sda_oe_n_out = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // data moves only after scl has been low a while, so the device's
  // synchronised scl never sees a false start or stop
  task automatic xbit(input logic b, output logic s);
    sda_oe_n_out = b;
    w(4);
    scl_out = 1'b1;
    w(8);
    s = sda_in;
    scl_out = 1'b0;
    w(4);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(last, ack);
  endtask

  task automatic start();
    sda_oe_n_out = 1'b1;
    w(4);
    scl_out = 1'b1;
    w(8);
    sda_oe_n_out = 1'b0;
    w(8);
    scl_out = 1'b0;
    w(4);
  endtask

  task automatic stop();
    sda_oe_n_out = 1'b0;
    w(4);
    scl_out = 1'b1;
    w(8);
    sda_oe_n_out = 1'b1;
    w(8);
  endtask

  task automatic reg_write(input logic [7:0] idx, input logic [23:0] d, input int n,
                           output logic nak);
    logic [7:0] q;
    logic       a;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, q, nak);
    xbyte(idx, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      xbyte(d[23-8*i -: 8], 1'b1, q, a);
    end
    stop();
  endtask

  // last byte is not acknowledged, which ends the read
  task automatic reg_read(input logic [7:0] idx, input int n, output logic [23:0] q,
                          output logic nak);
    logic [7:0] b;
    logic       a;
    q = '0;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, b, nak);
    xbyte(idx, 1'b1, b, a);
    start();
    xbyte({DEV_ADDR, 1'b1}, 1'b1, b, a);
    for (int i = 0; i < n; i++) begin
      xbyte(8'hff, (i == n - 1), b, a);
      q = {q[15:0], b};
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ==== hdl/ccr_config_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module ccr_config_regs #(
  parameter int         TICK_CYCLES_P = ccr_pkg::TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR      = 7'h40  // arbitrary value
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_n_out,
  input  wire logic             reg_reset_in,
  input  wire logic             watchdog_kick_in,
  input  wire logic [6:0]       fast_charge_current_in,
  output logic                  watchdog_kick_clear_out,
  output logic                  watchdog_expired_out,
  output ccr_pkg::ccr_cfg_t     cfg_out
);
  import ccr_pkg::*;

  typedef struct packed {
    ccr_cv_t     cv;
    ccr_tt_t     tt;
    ccr_ir_t     ir;
    logic [31:0] tick_cnt;
    logic [7:0]  sec_cnt;
    logic        kick_clr;
    logic        wd_fire;
    logic        live;
    ccr_cfg_t    cfg;
  } ccr_state_t;

  localparam ccr_state_t S_RESET = '{
    cv: RST_CHARGE_VOLTAGE,
    tt: RST_TERM_TIMER,
    ir: RST_IR_THERMAL,
    default: '0
  };
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES_P - 1);

  ccr_state_t s_r;
  ccr_state_t s_nxt;
  ccr_bus_t   bus;
  logic [7:0] rdata;

  ccr_i2c_slave #(
    .DEV_ADDR     (DEV_ADDR)
  ) u_link (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .rdata_in     (rdata),
    .bus_out      (bus),
    .sda_out      (sda_out),
    .sda_oe_n_out (sda_oe_n_out)
  );

  // read mux; unmapped indices read zero
  always_comb begin
    unique case (bus.rd_addr)
      ADDR_CHARGE_VOLTAGE: rdata = s_r.cv;
      ADDR_TERM_TIMER:     rdata = s_r.tt;
      ADDR_IR_THERMAL:     rdata = s_r.ir;
      default:             rdata = 8'h00;
    endcase
  end

  function automatic logic [7:0] period_s(input logic [1:0] code);
    logic [7:0] p;
    p = 8'h00;
    unique case (code)
      2'h0: p = 8'h00;
      2'h1: p = 8'(WD_BASE_S);
      2'h2: p = 8'(WD_BASE_S * 2);
      2'h3: p = 8'(WD_BASE_S * 4);
    endcase
    return p;
  endfunction

  function automatic logic [4:0] hours(input logic [1:0] code);
    logic [4:0] h;
    h = 5'h00;
    unique case (code)
      2'h0: h = 5'(SAFETY_H0);
      2'h1: h = 5'(SAFETY_H1);
      2'h2: h = 5'(SAFETY_H2);
      2'h3: h = 5'(SAFETY_H3);
    endcase
    return h;
  endfunction

  logic [31:0] vlim_mv;
  logic [31:0] fcur_ma;
  logic [31:0] ir_mv;
  logic [31:0] clamp_mv;
  logic [31:0] rcomp_mohm;
  logic [7:0]  wd_period;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.kick_clr = 1'b0;
    s_nxt.wd_fire  = 1'b0;
    // cfg_out is still zero on the first edge after reset, so checks wait for this flag
    s_nxt.live     = 1'b1;
    wd_period   = period_s(s_r.tt.watchdog_period);

    // register writes from the link
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_CHARGE_VOLTAGE: begin
          s_nxt.cv = bus.wdata;
          if (bus.wdata[7:2] > VLIM_MAX_CODE) begin
            s_nxt.cv.charge_voltage_limit = VLIM_MAX_CODE;
          end
        end
        ADDR_TERM_TIMER:     s_nxt.tt = bus.wdata;
        ADDR_IR_THERMAL:     s_nxt.ir = bus.wdata;
        default: ;
      endcase
    end

    // watchdog: one-second prescaler then a seconds count
    if (watchdog_kick_in || s_r.tt.watchdog_period == WD_CODE_OFF) begin
      s_nxt.tick_cnt = '0;
      s_nxt.sec_cnt  = '0;
      s_nxt.kick_clr = watchdog_kick_in;
    end else if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = '0;
      s_nxt.sec_cnt  = s_r.sec_cnt + 8'h01;
      if (s_r.sec_cnt + 8'h01 >= wd_period) begin
        s_nxt.wd_fire = 1'b1;
        s_nxt.sec_cnt = '0;
      end
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 32'h0000_0001;
    end

    // either reset source wins over a link write in the same cycle
    if (reg_reset_in || s_r.wd_fire) begin
      s_nxt.cv = RST_CHARGE_VOLTAGE;
      s_nxt.tt = RST_TERM_TIMER;
      s_nxt.ir = RST_IR_THERMAL;
    end

    // decoded settings, registered so consumers see glitch-free values
    vlim_mv    = 32'(VLIM_OFFSET_MV) + 32'(s_r.cv.charge_voltage_limit) * 32'(VLIM_LSB_MV);
    fcur_ma    = 32'(fast_charge_current_in) * 32'(FCUR_LSB_MA);
    rcomp_mohm = 32'(s_r.ir.ir_comp_resistance) * 32'(IRCOMP_LSB_MOHM);
    clamp_mv   = 32'(s_r.ir.ir_comp_voltage_max) * 32'(CLAMP_LSB_MV);
    ir_mv      = (fcur_ma * rcomp_mohm) / 32'(MOHM_PER_OHM);
    if (ir_mv > clamp_mv) begin
      ir_mv = clamp_mv;
    end

    s_nxt.cfg.charge_voltage_limit_mv  = 16'(vlim_mv);
    s_nxt.cfg.charge_voltage_target_mv = 16'(vlim_mv + ir_mv);
    s_nxt.cfg.precharge_exit_mv        = s_r.cv.precharge_exit_threshold ?
                                         16'(PRECHG_HIGH_MV) : 16'(PRECHG_LOW_MV);
    s_nxt.cfg.recharge_mv              = 16'(vlim_mv) - (s_r.cv.recharge_offset_sel ?
                                         16'(RECHG_LARGE_MV) : 16'(RECHG_SMALL_MV));
    s_nxt.cfg.term_en                  = s_r.tt.term_en;
    s_nxt.cfg.indicator_pin_off        = s_r.tt.indicator_pin_off;
    s_nxt.cfg.watchdog_period_s        = wd_period;
    s_nxt.cfg.safety_timer_en          = s_r.tt.safety_timer_en;
    s_nxt.cfg.fast_charge_hours        = hours(s_r.tt.fast_charge_duration);
    s_nxt.cfg.charge_enable            = fast_charge_current_in != 7'h00;
    s_nxt.cfg.cool_current_ma          = 16'(fcur_ma * (s_r.tt.cool_band_current_sel ?
                                         32'(COOL_PCT_FIFTH) : 32'(COOL_PCT_HALF))
                                         / 32'(PCT_FULL));
    s_nxt.cfg.ir_comp_resistance_mohm  = 8'(rcomp_mohm);
    s_nxt.cfg.ir_comp_voltage_max_mv   = 8'(clamp_mv);
    s_nxt.cfg.thermal_reg_threshold_c  = 8'(32'(THERM_BASE_C) +
                                         32'(s_r.ir.thermal_reg_threshold) * 32'(THERM_STEP_C));
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      s_r <= S_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg_out                 = s_r.cfg;
  assign watchdog_kick_clear_out = s_r.kick_clr;
  assign watchdog_expired_out    = s_r.wd_fire;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence reset_cause;
    reg_reset_in || s_r.wd_fire;
  endsequence

  sequence defaults_held;
    s_r.cv == RST_CHARGE_VOLTAGE && s_r.tt == RST_TERM_TIMER && s_r.ir == RST_IR_THERMAL;
  endsequence

  a_vlim_code_clamped: assert property (
    s_r.cv.charge_voltage_limit <= VLIM_MAX_CODE)
    else $error("voltage limit code above ceiling");

  a_limit_floor: assert property (
    s_r.live |-> cfg_out.charge_voltage_limit_mv >= 16'(VLIM_OFFSET_MV))
    else $error("voltage limit below offset");

  a_reset_to_defaults: assert property (
    reset_cause |=> defaults_held)
    else $error("registers not at defaults after reset source");

  a_expiry_pulse_once: assert property (
    s_r.wd_fire |=> !s_r.wd_fire ##0 defaults_held)
    else $error("expiry not a single pulse with defaults");

  a_kick_clears_bit: assert property (
    watchdog_kick_in |=> watchdog_kick_clear_out && s_r.sec_cnt == 8'h00
                         && s_r.tick_cnt == 32'h0000_0000)
    else $error("kick did not restart watchdog");

  a_kick_clear_cause: assert property (
    watchdog_kick_clear_out |-> $past(watchdog_kick_in))
    else $error("kick clear without a kick");

  a_wd_off_no_fire: assert property (
    s_r.tt.watchdog_period == WD_CODE_OFF |=> !s_r.wd_fire)
    else $error("watchdog fired while disabled");

  a_expiry_needs_period: assert property (
    s_r.wd_fire |-> $past(s_r.tt.watchdog_period) != WD_CODE_OFF)
    else $error("expiry with watchdog disabled");

  a_wd_period_map: assert property (
    s_r.live && $past(s_r.tt.watchdog_period) == 2'h1
      |-> cfg_out.watchdog_period_s == 8'(WD_BASE_S))
    else $error("default watchdog period wrong");

  a_write_lands: assert property (
    bus.wr && bus.addr == ADDR_TERM_TIMER && !reg_reset_in && !s_r.wd_fire
      |=> s_r.tt == $past(bus.wdata))
    else $error("timer register write lost");

  a_precharge_sel: assert property (
    s_r.live |-> cfg_out.precharge_exit_mv == ($past(s_r.cv.precharge_exit_threshold) ?
                                  16'(PRECHG_HIGH_MV) : 16'(PRECHG_LOW_MV)))
    else $error("precharge exit threshold wrong");

  a_recharge_offset: assert property (
    s_r.live |-> cfg_out.charge_voltage_limit_mv - cfg_out.recharge_mv ==
      ($past(s_r.cv.recharge_offset_sel) ? 16'(RECHG_LARGE_MV) : 16'(RECHG_SMALL_MV)))
    else $error("recharge offset wrong");

  a_term_and_pin: assert property (
    s_r.live |-> cfg_out.term_en == $past(s_r.tt.term_en)
      && cfg_out.indicator_pin_off == $past(s_r.tt.indicator_pin_off))
    else $error("termination or indicator setting lost");

  a_safety_enable: assert property (
    s_r.live |-> cfg_out.safety_timer_en == $past(s_r.tt.safety_timer_en))
    else $error("safety timer enable lost");

  a_target_bounded: assert property (
    cfg_out.charge_voltage_target_mv >= cfg_out.charge_voltage_limit_mv
      && cfg_out.charge_voltage_target_mv - cfg_out.charge_voltage_limit_mv
         <= 16'(cfg_out.ir_comp_voltage_max_mv))
    else $error("target outside limit plus clamp");

  a_ircomp_disabled: assert property (
    s_r.live && $past(s_r.ir.ir_comp_resistance) == 3'h0
      |-> cfg_out.charge_voltage_target_mv == cfg_out.charge_voltage_limit_mv)
    else $error("compensation active at zero resistance");

  a_zero_current_off: assert property (
    fast_charge_current_in == 7'h00 |=> !cfg_out.charge_enable)
    else $error("charging enabled at zero current");

  a_charge_on: assert property (
    fast_charge_current_in != 7'h00 |=> cfg_out.charge_enable)
    else $error("charging disabled at nonzero current");

  // truncation only ever rounds down, so an upper bound is exact enough
  a_cool_fraction: assert property (
    s_r.live && $past(s_r.tt.cool_band_current_sel)
      |-> 32'(cfg_out.cool_current_ma) * 32'(PCT_FULL)
          <= 32'($past(fast_charge_current_in)) * 32'(FCUR_LSB_MA) * 32'(COOL_PCT_FIFTH))
    else $error("cool band current above its fraction");

  a_safety_hours: assert property (
    s_r.live && $past(s_r.tt.fast_charge_duration) == 2'h2
      |-> cfg_out.fast_charge_hours == 5'(SAFETY_H2))
    else $error("safety duration decode wrong");

endmodule
`default_nettype wire

// ==== hdl/ccr_i2c_slave.sv ====
`timescale 1ns/100ps
`default_nettype none
module ccr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h40  // arbitrary value
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  input  wire logic [7:0]       rdata_in,
  output ccr_pkg::ccr_bus_t     bus_out,
  output logic                  sda_out,
  output logic                  sda_oe_n_out
);
  import ccr_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR  = 3'h1,
    S_AACK  = 3'h3,
    S_RX    = 3'h2,
    S_RXACK = 3'h6,
    S_TX    = 3'h7,
    S_TXACK = 3'h5,
    S_SKIP  = 3'h4
  } ccr_i2c_st_t;

  typedef struct packed {
    ccr_i2c_st_t st;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic        first;
    logic [7:0]  ptr;
    logic        drive;
    logic        wr;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
  } ccr_i2c_state_t;

  localparam ccr_i2c_state_t S_RESET = '{st: S_IDLE, scl_s: 3'h7, sda_s: 3'h7, default: '0};
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;

  ccr_i2c_state_t s_r;
  ccr_i2c_state_t s_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // only the second and third stages are read; the first is a pure synchroniser
  assign scl_rise   = s_r.scl_s[1] & ~s_r.scl_s[2];
  assign scl_fall   = ~s_r.scl_s[1] & s_r.scl_s[2];
  assign start_seen = s_r.scl_s[1] & s_r.scl_s[2] & ~s_r.sda_s[1] & s_r.sda_s[2];
  assign stop_seen  = s_r.scl_s[1] & s_r.scl_s[2] & s_r.sda_s[1] & ~s_r.sda_s[2];

  always_comb begin
    s_nxt       = s_r;
    s_nxt.wr    = 1'b0;
    s_nxt.scl_s = {s_r.scl_s[1:0], scl_in};
    s_nxt.sda_s = {s_r.sda_s[1:0], sda_in};
    if (start_seen) begin
      s_nxt.st    = S_ADDR;
      s_nxt.cnt   = '0;
      s_nxt.drive = 1'b0;
    end else if (stop_seen) begin
      s_nxt.st    = S_IDLE;
      s_nxt.drive = 1'b0;
    end else if (scl_rise) begin
      unique case (s_r.st)
        S_ADDR, S_RX: begin
          s_nxt.sh  = {s_r.sh[6:0], s_r.sda_s[1]};
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
        S_TXACK: if (s_r.sda_s[1]) s_nxt.st = S_SKIP;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (s_r.st)
        S_ADDR: if (s_r.cnt == BITS_PER_BYTE) begin
          if (s_r.sh[7:1] == DEV_ADDR) begin
            s_nxt.st    = S_AACK;
            s_nxt.drive = 1'b1;
            s_nxt.rw    = s_r.sh[0];
            s_nxt.first = 1'b1;
          end else begin
            s_nxt.st = S_SKIP;
          end
        end
        S_AACK, S_TXACK: begin
          s_nxt.cnt = '0;
          if (s_r.rw) begin
            s_nxt.st    = S_TX;
            s_nxt.sh    = rdata_in;
            s_nxt.drive = ~rdata_in[7];
            s_nxt.ptr   = s_r.ptr + 8'h01;
          end else begin
            s_nxt.st    = S_RX;
            s_nxt.drive = 1'b0;
          end
        end
        S_RX: if (s_r.cnt == BITS_PER_BYTE) begin
          s_nxt.st    = S_RXACK;
          s_nxt.drive = 1'b1;
          s_nxt.first = 1'b0;
          if (s_r.first) begin
            s_nxt.ptr = s_r.sh;
          end else begin
            s_nxt.wr    = 1'b1;
            s_nxt.waddr = s_r.ptr;
            s_nxt.wdata = s_r.sh;
            s_nxt.ptr   = s_r.ptr + 8'h01;
          end
        end
        S_RXACK: begin
          s_nxt.st    = S_RX;
          s_nxt.drive = 1'b0;
          s_nxt.cnt   = '0;
        end
        S_TX: begin
          s_nxt.cnt = s_r.cnt + 4'h1;
          if (s_r.cnt == LAST_TX_BIT) begin
            s_nxt.st    = S_TXACK;
            s_nxt.drive = 1'b0;
          end else begin
            s_nxt.sh    = {s_r.sh[6:0], 1'b0};
            s_nxt.drive = ~s_r.sh[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      s_r <= S_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_out      = '{wr: s_r.wr, addr: s_r.waddr, wdata: s_r.wdata, rd_addr: s_r.ptr};
  // open drain: the pad only ever pulls low
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~s_r.drive;

endmodule
`default_nettype wire

// ==== hdl/ccr_pkg.sv ====
package ccr_pkg;

  // register indices on the serial link
  localparam logic [7:0] ADDR_CHARGE_VOLTAGE = 8'h06;
  localparam logic [7:0] ADDR_TERM_TIMER     = 8'h07;
  localparam logic [7:0] ADDR_IR_THERMAL     = 8'h08;

  // reset values
  localparam logic [7:0] RST_CHARGE_VOLTAGE  = 8'h5e;
  localparam logic [7:0] RST_TERM_TIMER      = 8'h9d;
  localparam logic [7:0] RST_IR_THERMAL      = 8'h03;

  typedef struct packed {
    logic [5:0] charge_voltage_limit;
    logic       precharge_exit_threshold;
    logic       recharge_offset_sel;
  } ccr_cv_t;

  typedef struct packed {
    logic       term_en;
    logic       indicator_pin_off;
    logic [1:0] watchdog_period;
    logic       safety_timer_en;
    logic [1:0] fast_charge_duration;
    logic       cool_band_current_sel;
  } ccr_tt_t;

  typedef struct packed {
    logic [2:0] ir_comp_resistance;
    logic [2:0] ir_comp_voltage_max;
    logic [1:0] thermal_reg_threshold;
  } ccr_ir_t;

  localparam logic [5:0] VLIM_MAX_CODE       = 6'h30;
  localparam logic [1:0] WD_CODE_OFF         = 2'h0;

  // analog scaling, in mV, mA, milliohm, degC, %, s, h
  localparam int VLIM_OFFSET_MV      = 3840;
  localparam int VLIM_LSB_MV         = 16;
  localparam int PRECHG_LOW_MV       = 2800;
  localparam int PRECHG_HIGH_MV      = 3000;
  localparam int RECHG_SMALL_MV      = 100;
  localparam int RECHG_LARGE_MV      = 200;
  localparam int FCUR_LSB_MA         = 64;
  localparam int COOL_PCT_HALF       = 50;
  localparam int COOL_PCT_FIFTH      = 20;
  localparam int PCT_FULL            = 100;
  localparam int IRCOMP_LSB_MOHM     = 20;
  localparam int CLAMP_LSB_MV        = 32;
  localparam int MOHM_PER_OHM        = 1000;
  localparam int THERM_BASE_C        = 60;
  localparam int THERM_STEP_C        = 20;
  localparam int SAFETY_H0           = 5;
  localparam int SAFETY_H1           = 8;
  localparam int SAFETY_H2           = 12;
  localparam int SAFETY_H3           = 20;
  localparam int WD_BASE_S           = 40;

  // time base
  localparam int CLK_PERIOD_NS       = 20;
  localparam int ONE_SEC_NS          = 1000000000;
  localparam int TICK_CYCLES         = ONE_SEC_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd_addr;
  } ccr_bus_t;

  typedef struct packed {
    logic [15:0] charge_voltage_limit_mv;
    logic [15:0] charge_voltage_target_mv;
    logic [15:0] precharge_exit_mv;
    logic [15:0] recharge_mv;
    logic        term_en;
    logic        indicator_pin_off;
    logic [7:0]  watchdog_period_s;
    logic        safety_timer_en;
    logic [4:0]  fast_charge_hours;
    logic        charge_enable;
    logic [15:0] cool_current_ma;
    logic [7:0]  ir_comp_resistance_mohm;
    logic [7:0]  ir_comp_voltage_max_mv;
    logic [7:0]  thermal_reg_threshold_c;
  } ccr_cfg_t;

endpackage
